// ---- src/rlvc_map.svh ----
// How it works
// - highest vector number wins, vector zero first
// - all reset causes use vector zero
// - detector runs only when enable set
// - stop turns detector off unless stop-enable
// - both enables turn deep stop into shallow
// - power-on holds reset until supply recovers
// - power-on sets power-on and low-volt flags
// - low-volt reset enable resets, sets flag
// - one bit picks detector trip level
// - low-volt reset held until supply recovers
// - warning sets flag, enabled requests vector three
// - zero clock select leaves pin as port
// - nonzero select drives divided clock, overrides direction
// - division ratio follows clock select field
// - nine byte-wide control registers
// - pin slew and drive from register bits
// - request forwarded only when flag and enable
`ifndef RLVC_MAP_SVH
`define RLVC_MAP_SVH
`define RLVC_A_PWR 8'h00
`define RLVC_A_RSTAT 8'h04
`define RLVC_A_CLKO 8'h08
`define RLVC_A_ISTAT 8'h0C
`define RLVC_A_ICLR 8'h10
`define RLVC_A_IEN 8'h14
`define RLVC_A_VEC 8'h18
`define RLVC_A_STOP 8'h1C
`define RLVC_A_EXT 8'h20
`define RLVC_PWR_RESET 8'h01
`define RLVC_RSTAT_POR 8'h82
`define RLVC_B_LOW_VOLT_DETECT_ENABLE 0
`define RLVC_B_STOP_MODE_DETECT_ENABLE 1
`define RLVC_B_LOW_VOLT_RESET_ENABLE 2
`define RLVC_B_TRIP 3
`define RLVC_B_STOP_REQ 0
`define RLVC_B_STOP_DEEP 1
`define RLVC_F_SEL 2:0
`define RLVC_B_SLEW 3
`define RLVC_B_DRIVE 4
`define RLVC_I_WARN 0
`define RLVC_I_EXT 1
`define RLVC_I_PLL 2
`define RLVC_V_RESET 5'h00
`define RLVC_V_SWI 1
`define RLVC_V_EXT 2
`define RLVC_V_WARN 3
`define RLVC_V_PLL 4
`define RLVC_V_FIRST_PERIPH 5
`define RLVC_S_POR 7
`define RLVC_S_PIN 6
`define RLVC_S_WDOG 5
`define RLVC_S_BADOP 4
`define RLVC_S_BADADDR 3
`define RLVC_S_CLKLOSS 2
`define RLVC_S_LVD 1
`endif

// ---- src/rlvc_pkg.sv ----
package rlvc_pkg;
  typedef enum logic [1:0] {
    RLVC_RUN,
    RLVC_STOP2,
    RLVC_STOP3
  } rlvc_pmode_t;
  typedef enum logic {
    RLVC_ACTIVE,
    RLVC_HOLD
  } rlvc_rst_state_t;
  typedef logic [7:0] rlvc_byte_t;
endpackage

// ---- src/rlvc_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "rlvc_map.svh"
module rlvc_top #(
  parameter int NVEC = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic por_i,
  input wire logic supply_low_i,
  input wire logic warn_low_i,
  input wire logic wdog_rst_i,
  input wire logic clk_loss_rst_i,
  input wire logic pin_rst_i,
  input wire logic bad_op_rst_i,
  input wire logic bad_addr_rst_i,
  input wire logic dbg_rst_i,
  input wire logic swi_i,
  input wire logic ext_req_i,
  input wire logic pll_unlock_i,
  input wire logic [NVEC-1:0] periph_req_i,
  input wire logic wake_i,
  input wire logic port_data_i,
  input wire logic port_dir_i,
  output logic sys_rst_o,
  output logic [4:0] vec_o,
  output logic vec_valid_o,
  output logic irq_o,
  output logic detect_on_o,
  output logic trip_sel_o,
  output rlvc_pkg::rlvc_pmode_t pmode_o,
  output logic pin_o,
  output logic pin_oe_n_o,
  output logic pin_slew_o,
  output logic pin_drive_o
);
  import rlvc_pkg::*;

  // registers
  rlvc_byte_t pwr_ff, nxt_pwr;
  rlvc_byte_t rstat_ff, nxt_rstat;
  rlvc_byte_t clko_ff, nxt_clko;
  rlvc_byte_t istat_ff, nxt_istat;
  rlvc_byte_t ien_ff, nxt_ien;
  rlvc_byte_t ext_ff, nxt_ext;
  rlvc_byte_t cause_ff, nxt_cause;
  rlvc_rst_state_t rst_st_ff, nxt_rst_st;
  rlvc_pmode_t pmode_ff, nxt_pmode;
  logic [2:0] div_ff, nxt_div;
  logic clk_ff, nxt_clk;
  logic ack_ff;
  logic [31:0] dat_ff;
  logic irq_ff;
  logic [4:0] vec_ff;
  logic vec_valid_ff;
  logic pin_ff, pin_oe_n_ff;
  logic det_on_ff;

  // bus decode
  // a write lands only at the edge where ack is already high, so a master
  // that holds its request until it samples ack stores each write once;
  // a narrow write without the low byte lane selected is dropped
  wire req = wb_cyc_i & wb_stb_i;
  wire wr = req & wb_we_i & ack_ff & wb_sel_i[0];
  wire hit_pwr = wb_adr_i == `RLVC_A_PWR;
  wire hit_rstat = wb_adr_i == `RLVC_A_RSTAT;
  wire hit_clko = wb_adr_i == `RLVC_A_CLKO;
  wire hit_istat = wb_adr_i == `RLVC_A_ISTAT;
  wire hit_iclr = wb_adr_i == `RLVC_A_ICLR;
  wire hit_ien = wb_adr_i == `RLVC_A_IEN;
  wire hit_vec = wb_adr_i == `RLVC_A_VEC;
  wire hit_stop = wb_adr_i == `RLVC_A_STOP;
  wire hit_ext = wb_adr_i == `RLVC_A_EXT;
  wire [7:0] wdat = wb_dat_i[7:0];

  // control bits
  wire low_volt_detect_enable = pwr_ff[`RLVC_B_LOW_VOLT_DETECT_ENABLE];
  wire stop_mode_detect_enable = pwr_ff[`RLVC_B_STOP_MODE_DETECT_ENABLE];
  wire low_volt_reset_enable = pwr_ff[`RLVC_B_LOW_VOLT_RESET_ENABLE];
  wire [2:0] sel = clko_ff[`RLVC_F_SEL];

  // detector active in run, or in stop with stop-enable
  // the detector follows the current power mode, so leaving stop brings it
  // back on in the same cycle that the mode returns to run
  wire det_on = low_volt_detect_enable & ((pmode_ff == RLVC_RUN) | stop_mode_detect_enable);
  wire lvd_hit = det_on & low_volt_reset_enable & supply_low_i;

  // reset causes, all routed to the reset vector
  wire other_rst = wdog_rst_i | clk_loss_rst_i | pin_rst_i | bad_op_rst_i
                 | bad_addr_rst_i | dbg_rst_i;
  wire any_rst = por_i | lvd_hit | other_rst;
  rlvc_byte_t cause_now;
  assign cause_now = {por_i, pin_rst_i, wdog_rst_i, bad_op_rst_i, bad_addr_rst_i,
                      clk_loss_rst_i, por_i | lvd_hit, 1'b0};
  // release waits for supply above threshold after power-on or low-volt reset
  // other causes release as soon as their request drops; a supply still low
  // only holds reset when the power-on or low-volt flag is among the recorded causes
  wire supply_wait = (cause_ff[`RLVC_S_POR] | cause_ff[`RLVC_S_LVD]) & supply_low_i;
  wire release_now = (rst_st_ff == RLVC_HOLD) & ~any_rst & ~supply_wait;

  // interrupt events
  // the warning flag sets whenever the detector sees a warning, whatever the
  // enable; the enable only decides whether a request reaches the core
  wire warn_ev = det_on & warn_low_i;
  wire ext_ev = ext_req_i & ext_ff[0];
  rlvc_byte_t ev;
  assign ev = {5'h00, pll_unlock_i, ext_ev, warn_ev};
  rlvc_byte_t clr;
  assign clr = (wr & hit_iclr) ? wdat : 8'h00;
  rlvc_byte_t act;
  assign act = istat_ff & ien_ff;

  // pending vector set
  logic [NVEC-1:0] pend;
  always_comb begin
    pend = periph_req_i;
    pend[`RLVC_V_FIRST_PERIPH-1:0] = '0;
    pend[0] = rst_st_ff == RLVC_HOLD;
    pend[`RLVC_V_SWI] = swi_i;
    pend[`RLVC_V_EXT] = act[`RLVC_I_EXT];
    pend[`RLVC_V_WARN] = act[`RLVC_I_WARN];
    pend[`RLVC_V_PLL] = act[`RLVC_I_PLL];
  end

  // vector zero beats all, otherwise highest number wins
  // the scan runs upward so the last set bit found is the largest number;
  // the reset check comes last so it overrides any peripheral request
  function automatic logic [4:0] top_vec(input logic [NVEC-1:0] p);
    logic [4:0] v;
    v = `RLVC_V_RESET;
    for (int i = 1; i < NVEC; i++) begin
      if (p[i]) begin
        v = 5'(i);
      end
    end
    if (p[0]) begin
      v = `RLVC_V_RESET;
    end
    return v;
  endfunction
  wire [4:0] win = top_vec(pend);

  // reset sequencer
  // causes gather for the whole hold so that overlapping requests all show;
  // a fresh hold starts from an empty set so stale causes are dropped, and
  // software sees the set only once the system leaves reset
  always_comb begin
    nxt_rst_st = rst_st_ff;
    nxt_cause = cause_ff;
    nxt_rstat = rstat_ff;
    if (any_rst) begin
      nxt_rst_st = RLVC_HOLD;
      nxt_cause = ((rst_st_ff == RLVC_HOLD) ? cause_ff : 8'h00) | cause_now;
    end else if (release_now) begin
      nxt_rst_st = RLVC_ACTIVE;
      nxt_rstat = cause_ff;
    end
  end

  // power control and stop-mode entry
  // reset, and while already in stop a wake or pending irq, take priority over a new stop request; with both detector
  // enables set a deep request lands in the shallow mode, which keeps the
  // detector powered at the cost of higher standby current
  always_comb begin
    nxt_pwr = pwr_ff;
    nxt_pmode = pmode_ff;
    if (wr & hit_pwr) begin
      nxt_pwr = wdat & 8'h0F;
    end
    if ((pmode_ff != RLVC_RUN) & (wake_i | irq_ff)) begin
      nxt_pmode = RLVC_RUN;
    end else if (wr & hit_stop & wdat[`RLVC_B_STOP_REQ]) begin
      if (wdat[`RLVC_B_STOP_DEEP] & ~(low_volt_detect_enable & stop_mode_detect_enable)) begin
        nxt_pmode = RLVC_STOP2;
      end else begin
        nxt_pmode = RLVC_STOP3;
      end
    end
    if (rst_st_ff == RLVC_HOLD) begin
      nxt_pmode = RLVC_RUN;
    end
  end

  // interrupt flags, set wins over clear
  always_comb begin
    nxt_istat = (istat_ff & ~clr) | ev;
    nxt_ien = (wr & hit_ien) ? (wdat & 8'h07) : ien_ff;
    nxt_ext = (wr & hit_ext) ? (wdat & 8'h01) : ext_ff;
    nxt_clko = (wr & hit_clko) ? (wdat & 8'h1F) : clko_ff;
  end

  // clock output divider, ratio twice the select value
  // the output toggles every select cycles, so one full period spans twice
  // the select value; a zero select parks the divider and the output low
  always_comb begin
    nxt_div = div_ff;
    nxt_clk = clk_ff;
    if (sel == 3'h0) begin
      nxt_div = 3'h0;
      nxt_clk = 1'b0;
    end else if (div_ff + 3'h1 >= sel) begin
      nxt_div = 3'h0;
      nxt_clk = ~clk_ff;
    end else begin
      nxt_div = div_ff + 3'h1;
    end
  end

  // read mux
  logic [7:0] rdat;
  always_comb begin
    rdat = 8'h00;
    if (hit_pwr) begin
      rdat = pwr_ff;
    end else if (hit_rstat) begin
      rdat = rstat_ff;
    end else if (hit_clko) begin
      rdat = clko_ff;
    end else if (hit_istat) begin
      rdat = istat_ff;
    end else if (hit_ien) begin
      rdat = ien_ff;
    end else if (hit_vec) begin
      rdat = {3'h0, vec_ff};
    end else if (hit_stop) begin
      rdat = {6'h00, pmode_ff};
    end else if (hit_ext) begin
      rdat = ext_ff;
    end
  end

  // wishbone slave
  // every request is answered one cycle after it is taken, mapped or not,
  // so a master never waits on an unmapped address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req & ~ack_ff;
      dat_ff <= (req & ~ack_ff & ~wb_we_i) ? {24'h000000, rdat} : 32'h0000_0000;
    end
  end

  // control state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_ff <= `RLVC_PWR_RESET;
      rstat_ff <= `RLVC_RSTAT_POR;
      cause_ff <= `RLVC_RSTAT_POR;
      rst_st_ff <= RLVC_HOLD;
      pmode_ff <= RLVC_RUN;
      istat_ff <= 8'h00;
      ien_ff <= 8'h00;
      ext_ff <= 8'h00;
      clko_ff <= 8'h00;
    end else begin
      pwr_ff <= nxt_pwr;
      rstat_ff <= nxt_rstat;
      cause_ff <= nxt_cause;
      rst_st_ff <= nxt_rst_st;
      pmode_ff <= nxt_pmode;
      istat_ff <= nxt_istat;
      ien_ff <= nxt_ien;
      ext_ff <= nxt_ext;
      clko_ff <= nxt_clko;
    end
  end

  // divider and registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_ff <= 3'h0;
      clk_ff <= 1'b0;
      irq_ff <= 1'b0;
      vec_ff <= `RLVC_V_RESET;
      vec_valid_ff <= 1'b0;
      pin_ff <= 1'b0;
      pin_oe_n_ff <= 1'b1;
    end else begin
      div_ff <= nxt_div;
      clk_ff <= nxt_clk;
      irq_ff <= |act;
      vec_ff <= win;
      vec_valid_ff <= |pend;
      pin_ff <= (sel != 3'h0) ? nxt_clk : port_data_i;
      pin_oe_n_ff <= (sel != 3'h0) ? 1'b0 : ~port_dir_i;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign sys_rst_o = rst_st_ff == RLVC_HOLD;
  assign vec_o = vec_ff;
  assign vec_valid_o = vec_valid_ff;
  assign irq_o = irq_ff;
  assign detect_on_o = det_on_ff;
  assign trip_sel_o = pwr_ff[`RLVC_B_TRIP];
  assign pmode_o = pmode_ff;
  assign pin_o = pin_ff;
  assign pin_oe_n_o = pin_oe_n_ff;
  assign pin_slew_o = clko_ff[`RLVC_B_SLEW];
  assign pin_drive_o = clko_ff[`RLVC_B_DRIVE];

  // detector enable output kept in a flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      det_on_ff <= 1'b0;
    end else begin
      det_on_ff <= det_on;
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  reset_vector_top_a: assert property (
    sys_rst_o |=> vec_o == 5'h00 && vec_valid_o)
    else $error("reset not on vector zero");
  vector_rank_a: assert property (
    !pend[0] && pend[3] && !(|pend[NVEC-1:4]) |=> vec_o == 5'h03)
    else $error("vector rank wrong");
  cause_reset_a: assert property (
    wdog_rst_i |=> sys_rst_o)
    else $error("watchdog did not reset");
  detect_gate_a: assert property (
    !pwr_ff[0] |=> !detect_on_o)
    else $error("detector on while disabled");
  stop_detect_a: assert property (
    pmode_ff != RLVC_RUN && !stop_mode_detect_enable |=> !detect_on_o)
    else $error("detector on in stop");
  stop_shallow_a: assert property (
    low_volt_detect_enable && stop_mode_detect_enable && !sys_rst_o |-> pmode_o != RLVC_STOP2)
    else $error("deep stop with detector kept");
  supply_hold_a: assert property (
    sys_rst_o && cause_ff[`RLVC_S_POR] && supply_low_i |=> sys_rst_o)
    else $error("released under low supply");
  lvd_reset_a: assert property (
    lvd_hit && !sys_rst_o |=> sys_rst_o ##0 cause_ff[`RLVC_S_LVD])
    else $error("low-volt reset missed");
  warn_flag_a: assert property (
    warn_ev |=> istat_ff[`RLVC_I_WARN])
    else $error("warning flag not set");
  irq_gate_a: assert property (
    ((istat_ff & ien_ff) == 8'h00) |=> !irq_o)
    else $error("irq without enabled flag");
  clk_pin_a: assert property (
    sel != 3'h0 && $stable(sel) |=> !pin_oe_n_o)
    else $error("clock pin not driven");
  release_flag_a: assert property (
    release_now |=> rstat_ff == $past(cause_ff))
    else $error("status not latched");
  // pin, bus and flag checks
  pin_port_a: assert property (
    sel == 3'h0 |=> pin_o == $past(port_data_i) && pin_oe_n_o == !$past(port_dir_i))
    else $error("pin not left to port");
  warn_request_a: assert property (
    warn_ev ##1 act[`RLVC_I_WARN] |=> irq_o)
    else $error("warning request missing");
  por_flags_a: assert property (
    por_i |=> cause_ff[`RLVC_S_POR] && cause_ff[`RLVC_S_LVD])
    else $error("power-on flags missing");
  ack_pulse_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  cov_lvd_reset_c: cover property (lvd_hit ##1 sys_rst_o);
  cov_por_release_c: cover property (sys_rst_o ##1 !sys_rst_o);
  cov_warn_irq_c: cover property (warn_ev ##[1:3] irq_o);
  cov_stop3_c: cover property (pmode_o == RLVC_STOP3);
  cov_clkout_c: cover property (sel == 3'h3 ##1 pin_o ##1 !pin_o);
endmodule
`default_nettype wire

// ---- testbench/rlvc_cpu_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// core side: raises the software request and latches each offered vector
module rlvc_cpu_model (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [4:0] vec_i,
  input wire logic vec_valid_i,
  input wire logic swi_cmd_i,
  output logic swi_o,
  output logic [4:0] taken_o
);
  // no instruction executes, so no software request, while in reset
  always_ff @(posedge clk_i) begin
    swi_o <= swi_cmd_i & ~sys_rst_i;
    if (vec_valid_i) begin
      taken_o <= vec_i;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "rlvc_map.svh"
module tb_top;
  import rlvc_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, por = 0, slo = 0, wrn = 0;
  logic ext = 0, pll = 0, wake = 0, pd = 0, pdir = 0, swi_cmd = 0, swi;
  logic [7:0] adr = 0;
  logic [31:0] wdat = 0, per = 0, seed = 32'h1354, dat;
  logic [5:0] rq = 0;
  logic ack, sys_rst, vv, irq, det, trip, pin, oen, slew, drv;
  logic [4:0] vec, taken;
  rlvc_pmode_t pmode;
  logic [7:0] q[$];
  logic [7:0] src_exp[6] = '{8'h20, 8'h04, 8'h40, 8'h10, 8'h08, 8'h00};
  int fail_count = 0, check_count = 0, cycles = 0, k, n;
  // bench clock, 4 ns period
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  rlvc_top rlvc_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat),
    .wb_ack_o(ack), .por_i(por), .supply_low_i(slo), .warn_low_i(wrn), .wdog_rst_i(rq[0]),
    .clk_loss_rst_i(rq[1]), .pin_rst_i(rq[2]), .bad_op_rst_i(rq[3]),
    .bad_addr_rst_i(rq[4]), .dbg_rst_i(rq[5]), .swi_i(swi), .ext_req_i(ext),
    .pll_unlock_i(pll), .periph_req_i(per), .wake_i(wake), .port_data_i(pd),
    .port_dir_i(pdir), .sys_rst_o(sys_rst), .vec_o(vec), .vec_valid_o(vv), .irq_o(irq),
    .detect_on_o(det), .trip_sel_o(trip), .pmode_o(pmode), .pin_o(pin),
    .pin_oe_n_o(oen), .pin_slew_o(slew), .pin_drive_o(drv));
  rlvc_cpu_model rlvc_cpu_model_i (.clk_i(clk_i), .sys_rst_i(sys_rst), .vec_i(vec),
    .vec_valid_i(vv), .swi_cmd_i(swi_cmd), .swi_o(swi), .taken_o(taken));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic w(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  // one classic cycle, released at the edge that samples ack
  task automatic wb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    cyc <= 1;
    we <= wr;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && t < 50);
    if (ack !== 1'b1) begin
      fail_count++;
      $display("[FAIL] %0t no bus answer", $time);
    end
    cyc <= 0;
    we <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    wb(0, a, 8'h00);
  endtask
  // read watcher takes the oldest note at each read answer
  always @(posedge clk_i) begin
    if (ack === 1'b1 && cyc && !we) begin
      chk(dat[7:0], q.pop_front());
      chk(8'(dat[31:8] != 0), 8'h00);
    end
  end
  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    w(6);
    rst_i <= 0;
    slo <= 1;
    w(5);
    chk(8'(sys_rst), 8'h01);
    slo <= 0;
    w(4);
    chk(8'(sys_rst), 8'h00);
    chk(8'(det), 8'h01);
    rd(`RLVC_A_PWR, 8'h01);
    rd(`RLVC_A_RSTAT, 8'h82);
    wb(1, `RLVC_A_RSTAT, 8'hFF);
    rd(`RLVC_A_RSTAT, 8'h82);
    seed = lfsr(seed);
    wb(1, 8'h40, seed[7:0]);
    rd(8'h40, 8'h00);
    // masked source stays silent, enabled one is forwarded
    wb(1, `RLVC_A_EXT, 8'h01);
    ext <= 1;
    w(1);
    ext <= 0;
    w(4);
    chk(8'(vv), 8'h00);
    wb(1, `RLVC_A_IEN, 8'h02);
    w(3);
    chk(8'(irq), 8'h01);
    chk(8'(vec), 8'h02);
    seed = lfsr(seed);
    k = 5 + int'(seed[4:0]) % 27;
    per <= 32'h1 << k;
    swi_cmd <= 1;
    w(4);
    chk(8'(taken), 8'(k));
    per <= 0;
    w(4);
    chk(8'(vec), 8'h02);
    wb(1, `RLVC_A_ICLR, 8'h02);
    w(3);
    chk(8'(vec), 8'h01);
    swi_cmd <= 0;
    // warning flag sets regardless, request only when enabled
    wrn <= 1;
    w(1);
    wrn <= 0;
    w(3);
    rd(`RLVC_A_ISTAT, 8'h01);
    chk(8'(irq), 8'h00);
    wb(1, `RLVC_A_IEN, 8'h01);
    w(3);
    chk(8'(vec), 8'h03);
    chk(8'(irq), 8'h01);
    wb(1, `RLVC_A_ICLR, 8'h07);
    wb(1, `RLVC_A_IEN, 8'h00);
    // each of the six non-supply reset causes uses vector zero and leaves only its own flag, the debug reset none
    for (int i = 0; i < 6; i++) begin
      swi_cmd <= 1;
      w(3);
      rq <= 6'h01 << i;
      w(3);
      chk(8'(sys_rst), 8'h01);
      chk(8'(vec), 8'h00);
      rq <= 0;
      swi_cmd <= 0;
      w(5);
      rd(`RLVC_A_RSTAT, src_exp[i]);
    end
    wb(1, `RLVC_A_PWR, 8'h05);
    slo <= 1;
    w(10);
    chk(8'(sys_rst), 8'h01);
    slo <= 0;
    w(5);
    rd(`RLVC_A_RSTAT, 8'h02);
    wb(1, `RLVC_A_PWR, 8'h08);
    w(3);
    chk(8'(trip), 8'h01);
    chk(8'(det), 8'h00);
    // stop entry: both enables turn deep into shallow, else detector off
    for (int i = 0; i < 2; i++) begin
      wb(1, `RLVC_A_PWR, i ? 8'h01 : 8'h03);
      wb(1, `RLVC_A_STOP, 8'h03);
      w(3);
      chk(8'(pmode), i ? 8'(RLVC_STOP2) : 8'(RLVC_STOP3));
      chk(8'(det), i ? 8'h00 : 8'h01);
      wake <= 1;
      w(1);
      wake <= 0;
      w(3);
      chk(8'(pmode), 8'(RLVC_RUN));
    end
    // clock output off then divided by twice the select value
    pd <= 1;
    wb(1, `RLVC_A_CLKO, 8'h00);
    w(3);
    chk(8'({oen, pin}), 8'h03);
    wb(1, `RLVC_A_CLKO, 8'h1A);
    w(4);
    chk(8'({slew, drv, oen}), 8'h06);
    n = 0;
    for (int i = 0; i < 16; i++) begin
      k = pin;
      w(1);
      n += (pin != k);
    end
    chk(8'(n), 8'h08);
    results();
  end
endmodule
`default_nettype wire
